/* src/crf_defines.vh */
// register map, field positions, reset values and fixed levels of the char recognition block
`ifndef CRF_DEFINES_VH
`define CRF_DEFINES_VH
// register byte offsets (one aligned word each)
`define CRF_OFF_MODE0    8'h00
`define CRF_OFF_XON      8'h04
`define CRF_OFF_XOFF     8'h08
`define CRF_OFF_ADDR     8'h0C
`define CRF_OFF_STATUS   8'h10
`define CRF_OFF_MASK     8'h14
`define CRF_OFF_TXSTATE  8'h18
// mode_reg_zero fields
`define CRF_MODE_AUTOTX  2
`define CRF_MODE_AUTORX  3
`define CRF_MODE_STRIPWA 4
`define CRF_MODE_TRANSP  7
// status bit positions
`define CRF_ST_XON       0
`define CRF_ST_XOFF      1
`define CRF_ST_ADDR      2
// reset values
`define CRF_XON_RST      8'h11
`define CRF_XOFF_RST     8'h13
`define CRF_ADDR_RST     8'h00
`define CRF_MODE_RST     8'h00
// fill thresholds
`define CRF_FILL_HI      9'h0F0
`define CRF_FILL_LO      9'h010
// bus answers
`define CRF_RESP_OKAY    2'h0
`define CRF_RESP_SLVERR  2'h2
`endif

/* src/crf_char_recog.v */
// character recognition and in-band flow control for one receive channel
// Functional notes
// R1 - three match characters: xon, xoff, wake address
// R2 - match sets flow and channel status bits
// R3 - reading flow status clears recognition bits
// R4 - resets load standard xon and xoff values
// R5 - xon resets to 11, xoff to 13
// R6 - mode strips matched characters or passes them
// R7 - recognition acts whether stripped or not
// R8 - errored matched characters always enter fifo
// R9 - mode field: host, autotx, autorx, both
// R10 - mode bits 3:2 reset to zero
// R11 - bit 2: xoff stops, xon restarts transmitter
// R12 - xoff halts after current character finishes
// R13 - bit 3: send xon/xoff on fill levels
// R14 - xoff above 240 filled, xon below 16
// R15 - bit 7 drops xon/xoff from fifo
// R16 - bit 7 independent of mode bits 3:2
// R17 - match needs all data bits equal
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "crf_defines.vh"

module crf_char_recog #(
  parameter DW = 8,
  parameter FW = 9
) (
  // clock and reset
  input  wire          aclk,
  input  wire          aresetn,
  // axi4-lite write address and data
  input  wire [7:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  // axi4-lite read
  input  wire [7:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  // received characters heading for the receive_fifo
  input  wire [DW-1:0] rx_char,
  input  wire          rx_err,
  input  wire          rx_valid,
  input  wire          rx_fifo_room,
  input  wire [FW-1:0] rx_fill,
  // to the receive_fifo
  output reg  [DW-1:0] fifo_char,
  output reg           fifo_err,
  output reg           fifo_wr,
  // transmitter side
  input  wire          tx_char_busy,
  output reg           tx_enable,
  output reg           tx_fc_req,
  output reg  [DW-1:0] tx_fc_char,
  input  wire          tx_fc_ack,
  // events to the channel_irq_status_reg and interrupt line
  output reg           chan_irq_event,
  output reg           irq
);

  // mode_reg_zero and character registers
  reg [7:0]    mode_reg_zero;
  reg [DW-1:0] xon_char;
  reg [DW-1:0] xoff_char;
  reg [DW-1:0] addr_char;
  // flow_char_status_reg sticky bits and mask
  reg [2:0]    flow_char_status_reg;
  reg [2:0]    irq_mask;
  // flow control state
  reg          halt_pend;
  reg          tx_halted;
  reg          xoff_sent;

  // axi bookkeeping
  reg          aw_held;
  reg          w_held;
  reg [7:0]    aw_addr;
  reg [31:0]   w_data;
  reg [3:0]    w_strb;

  // whole-character compare used three times
  function match;
    input [DW-1:0] a;
    input [DW-1:0] b;
    begin
      match = (a == b);
    end
  endfunction

  // byte-lane merge for the narrow registers
  function [7:0] lane0;
    input [7:0]  old;
    input [31:0] d;
    input [3:0]  s;
    begin
      lane0 = s[0] ? d[7:0] : old;
    end
  endfunction

  // registers a write may change; status and tx state are read-only
  function writable;
    input [7:0] a;
    begin
      writable = (a == `CRF_OFF_MODE0) | (a == `CRF_OFF_XON)
               | (a == `CRF_OFF_XOFF) | (a == `CRF_OFF_ADDR)
               | (a == `CRF_OFF_MASK);
    end
  endfunction

  wire hit_xon  = match(rx_char, xon_char);  // R17
  wire hit_xoff = match(rx_char, xoff_char); // R17
  wire hit_addr = match(rx_char, addr_char); // R1
  // an overrun character is neither recognised nor loaded; gating the
  // hits here keeps every consumer of a match consistent with the fifo
  wire take     = rx_valid & rx_fifo_room;
  wire [2:0] hits = {hit_addr, hit_xoff, hit_xon} & {3{take}};
  wire fc_hit   = hits[`CRF_ST_XON] | hits[`CRF_ST_XOFF];

  // strip decision; errored characters always go through
  wire strip = ~rx_err & ((fc_hit & mode_reg_zero[`CRF_MODE_TRANSP])        // R15 R16
             | (hits[`CRF_ST_ADDR] & mode_reg_zero[`CRF_MODE_STRIPWA])); // R6 R8

  wire auto_tx = mode_reg_zero[`CRF_MODE_AUTOTX]; // R9
  wire auto_rx = mode_reg_zero[`CRF_MODE_AUTORX]; // R9

  // bus handshakes
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire do_read  = s_axi_arvalid & s_axi_arready;
  wire st_read  = do_read & (s_axi_araddr == `CRF_OFF_STATUS);

  // write channel capture: address and data accepted in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CRF_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= writable(aw_addr) ? `CRF_RESP_OKAY : `CRF_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // writable registers; resets restore standard flow characters
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg_zero <= `CRF_MODE_RST; // R10
      xon_char      <= `CRF_XON_RST;  // R4 R5
      xoff_char     <= `CRF_XOFF_RST; // R4 R5
      addr_char     <= `CRF_ADDR_RST;
      irq_mask      <= 3'h0;
    end else if (do_write) begin
      case (aw_addr)
        `CRF_OFF_MODE0: mode_reg_zero <= lane0(mode_reg_zero, w_data, w_strb);
        `CRF_OFF_XON:   xon_char      <= lane0(xon_char, w_data, w_strb);
        `CRF_OFF_XOFF:  xoff_char     <= lane0(xoff_char, w_data, w_strb);
        `CRF_OFF_ADDR:  addr_char     <= lane0(addr_char, w_data, w_strb);
        `CRF_OFF_MASK:  irq_mask      <= w_strb[0] ? w_data[2:0] : irq_mask;
        default:        irq_mask      <= irq_mask;
      endcase
    end
  end

  // read channel: one read at a time, answer one cycle after accept
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CRF_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `CRF_RESP_OKAY;
        case (s_axi_araddr)
          `CRF_OFF_MODE0:   s_axi_rdata <= {24'h000000, mode_reg_zero};
          `CRF_OFF_XON:     s_axi_rdata <= {24'h000000, xon_char};
          `CRF_OFF_XOFF:    s_axi_rdata <= {24'h000000, xoff_char};
          `CRF_OFF_ADDR:    s_axi_rdata <= {24'h000000, addr_char};
          `CRF_OFF_STATUS:  s_axi_rdata <= {29'h00000000, flow_char_status_reg};
          `CRF_OFF_MASK:    s_axi_rdata <= {29'h00000000, irq_mask};
          `CRF_OFF_TXSTATE: s_axi_rdata <= {29'h00000000, xoff_sent, halt_pend, tx_halted};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CRF_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // next status: a match in the cycle of a clearing read is not lost
  reg [2:0]    next_status;
  always @* begin
    next_status = flow_char_status_reg;
    if (st_read) begin
      next_status = 3'h0; // R3
    end
    next_status = next_status | hits; // R2 R7
  end

  // sticky status: set wins over clear-on-read
  always @(posedge aclk) begin
    if (!aresetn) begin
      flow_char_status_reg <= 3'h0;
      chan_irq_event       <= 1'b0;
      irq                  <= 1'b0;
    end else begin
      flow_char_status_reg <= next_status; // R2 R3
      chan_irq_event       <= |hits; // R2
      irq                  <= |(flow_char_status_reg & irq_mask);
    end
  end

  // receive path toward the fifo, one cycle of latency
  always @(posedge aclk) begin
    if (!aresetn) begin
      fifo_char <= {DW{1'b0}};
      fifo_err  <= 1'b0;
      fifo_wr   <= 1'b0;
    end else begin
      fifo_char <= rx_char;
      fifo_err  <= rx_err;
      fifo_wr   <= take & ~strip; // R6 R8
    end
  end

  // next halt state: xon wins over xoff, leaving the mode releases all
  reg          next_halt_pend;
  reg          next_tx_halted;
  always @* begin
    next_halt_pend = halt_pend;
    next_tx_halted = tx_halted;
    if (!auto_tx) begin
      next_halt_pend = 1'b0;
      next_tx_halted = 1'b0;
    end else if (hits[`CRF_ST_XON]) begin // R11
      next_halt_pend = 1'b0;
      next_tx_halted = 1'b0;
    end else if (hits[`CRF_ST_XOFF]) begin // R11
      next_halt_pend = 1'b1;
    end else if (halt_pend && !tx_char_busy) begin // R12
      next_halt_pend = 1'b0;
      next_tx_halted = 1'b1;
    end
  end

  // transmitter gating: enable drops at the very edge the halt is taken,
  // so the transmitter gets no chance to start another character first
  always @(posedge aclk) begin
    if (!aresetn) begin
      halt_pend <= 1'b0;
      tx_halted <= 1'b0;
      tx_enable <= 1'b1;
    end else begin
      halt_pend <= next_halt_pend;
      tx_halted <= next_tx_halted;
      tx_enable <= ~next_tx_halted; // R12
    end
  end

  // auto-receiver decisions, kept apart from the register updates
  reg          next_fc_req;
  reg [DW-1:0] next_fc_char;
  reg          next_xoff_sent;
  wire         req_is_xoff = (tx_fc_char == xoff_char);
  wire         fill_high   = (rx_fill > `CRF_FILL_HI);
  wire         fill_low    = (rx_fill < `CRF_FILL_LO);
  always @* begin
    next_fc_req    = tx_fc_req;
    next_fc_char   = tx_fc_char;
    next_xoff_sent = xoff_sent;
    if (!auto_rx) begin
      // leaving the mode forgets any outstanding xoff, no xon is sent
      next_fc_req    = 1'b0;
      next_xoff_sent = 1'b0;
    end else if (tx_fc_req) begin
      if (tx_fc_ack) begin
        next_fc_req    = 1'b0;
        next_xoff_sent = req_is_xoff;
      end else if (req_is_xoff ? !fill_high : !fill_low) begin
        // level negated before the character went out: withdraw it
        next_fc_req = 1'b0;
      end
    end else if (!xoff_sent && fill_high) begin // R13 R14
      next_fc_req  = 1'b1;
      next_fc_char = xoff_char;
    end else if (xoff_sent && fill_low) begin // R13 R14
      next_fc_req  = 1'b1;
      next_fc_char = xon_char;
    end
  end

  // flow character request registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_fc_req  <= 1'b0;
      tx_fc_char <= {DW{1'b0}};
      xoff_sent  <= 1'b0;
    end else begin
      tx_fc_req  <= next_fc_req;
      tx_fc_char <= next_fc_char;
      xoff_sent  <= next_xoff_sent;
    end
  end

endmodule

/* dv/crf_char_recog_properties.sv */
// port-level assertions for the char recognition block
`timescale 1ns/1ps
module crf_chk #(
  parameter DW = 8
) (
  // clock and reset
  input wire logic          aclk, aresetn,
  // receive path
  input wire logic [DW-1:0] rx_char, fifo_char, tx_fc_char,
  input wire logic          rx_err, rx_valid, rx_fifo_room, fifo_err, fifo_wr,
  // transmitter, events and reads
  input wire logic          tx_char_busy, tx_enable, tx_fc_req, tx_fc_ack,
  input wire logic          chan_irq_event, irq, s_axi_rvalid,
  input wire logic [31:0]   s_axi_rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic take;
  // an overrun character must leave no trace, so only these count
  assign take = rx_valid && rx_fifo_room;
  property p_rst; $rose(aresetn) |-> tx_enable && !tx_fc_req && !irq; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_room; rx_valid && !rx_fifo_room |=> !fifo_wr && !chan_irq_event; endproperty
  a_room: assert property (p_room) else $error("overrun char acted on");
  property p_copy;
    fifo_wr |-> $past(take) && fifo_char == $past(rx_char) && fifo_err == $past(rx_err);
  endproperty
  a_copy: assert property (p_copy) else $error("fifo write wrong");
  property p_err; take && rx_err |=> fifo_wr; endproperty
  a_err: assert property (p_err) else $error("errored char dropped");
  property p_strip; take |=> fifo_wr || chan_irq_event; endproperty
  a_strip: assert property (p_strip) else $error("plain char dropped");
  property p_evt; chan_irq_event |-> $past(take); endproperty
  a_evt: assert property (p_evt) else $error("event without char");
  property p_fc_drop; tx_fc_req && tx_fc_ack |=> !tx_fc_req; endproperty
  a_fc_drop: assert property (p_fc_drop) else $error("flow request kept");
  property p_fc_hold; tx_fc_req && !tx_fc_ack |=> !tx_fc_req || $stable(tx_fc_char); endproperty
  a_fc_hold: assert property (p_fc_hold) else $error("flow char moved");
  property p_halt; $fell(tx_enable) |-> !$past(tx_char_busy); endproperty
  a_halt: assert property (p_halt) else $error("halt cut a char");
  property p_narrow; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
  a_narrow: assert property (p_narrow) else $error("read upper bits set");
  c_strip: cover property (take ##1 !fifo_wr);
  c_halt: cover property ($fell(tx_enable));
  c_fc: cover property (tx_fc_req && tx_fc_ack);
endmodule
bind crf_char_recog crf_chk #(.DW(DW)) u_chk (.*);

/* dv/crf_far_end.sv */
// transmitter stand-in: shifts characters and loads flow characters on request
`timescale 1ns/1ps
module crf_far_end (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // gating and flow request
  input  wire logic       tx_enable,
  input  wire logic       tx_fc_req,
  input  wire logic [7:0] tx_fc_char,
  // answers
  output logic            tx_char_busy,
  output logic            tx_fc_ack,
  output logic [7:0]      sent_char
);
  logic [2:0] ph;
  // busy half of every 8 cycles, so a halt must wait for the idle half
  always @(posedge aclk) begin
    ph <= aresetn ? ph + 3'h1 : 3'h0;
    tx_char_busy <= aresetn && tx_enable && ph[2];
    tx_fc_ack <= aresetn && tx_fc_req && !tx_fc_ack && ph == 3'h7;
    if (!aresetn) begin
      sent_char <= 8'h00;
    end else if (tx_fc_req && !tx_fc_ack && ph == 3'h7) begin
      sent_char <= tx_fc_char;
    end
  end
endmodule

/* dv/tb_crf_char_recog.sv */
// self-checking bench: registers, matching, stripping and flow control
`timescale 1ns/1ps
`include "crf_defines.vh"
module tb_crf_char_recog;
  localparam logic [7:0] ST = `CRF_OFF_STATUS;
  localparam logic [7:0] MD = `CRF_OFF_MODE0;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rx_char = 8'h00;
  logic [7:0] fifo_char, tx_fc_char, sent_char;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [8:0] rx_fill = 9'h000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic rx_err = 1'b0, rx_valid = 1'b0, rx_fifo_room = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic fifo_err, fifo_wr, tx_char_busy, tx_enable, tx_fc_req, tx_fc_ack;
  logic chan_irq_event, irq;
  int mismatches = 0, checks = 0;
  crf_char_recog u_dut (.*);
  crf_far_end u_far (.*);
  // 200 MHz clock
  always #2.5 aclk = ~aclk;
  task automatic chk(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic finish_test;
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // halves are released as each is taken; the answer is waited for
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (s_axi_awready && !ta) begin ta = 1'b1; s_axi_awvalid <= 1'b0; end
      if (s_axi_wready && !tw) begin tw = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, er);
    @(posedge aclk);
  endtask
  // one character toward the fifo, then whether it was written
  task automatic rx(input logic [7:0] c, input logic e, w);
    rx_char <= c;
    rx_err <= e;
    rx_valid <= 1'b1;
    @(posedge aclk);
    rx_valid <= 1'b0;
    #1 chk(fifo_wr, w);
    @(posedge aclk);
  endtask
  // hang guard, far above the two hundred or so cycles needed
  initial begin
    #100us;
    mismatches++;
    $display("BAD %0t timeout", $time);
    finish_test;
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`CRF_OFF_XON, 32'h11, 2'h0);
    rd(`CRF_OFF_XOFF, 32'h13, 2'h0);
    rd(MD, 32'h0, 2'h0);
    rd(8'h1C, 32'h0, 2'h2);
    wr(ST, 32'h7, 2'h2);
    wr(`CRF_OFF_ADDR, 32'h55, 2'h0);
    wr(`CRF_OFF_MASK, 32'h7, 2'h0);
    rx(8'h41, 1'b0, 1'b1);
    rx(8'h13, 1'b0, 1'b1);
    @(posedge aclk);
    chk(irq, 1'b1);
    rd(ST, 32'h2, 2'h0);
    rd(ST, 32'h0, 2'h0);
    chk(irq, 1'b0);
    wr(MD, 32'h84, 2'h0);
    rx(8'h13, 1'b0, 1'b0);
    repeat (10) @(posedge aclk);
    chk(tx_enable, 1'b0);
    rx(8'h13, 1'b1, 1'b1);
    rx(8'h11, 1'b0, 1'b0);
    chk(tx_enable, 1'b1);
    rd(ST, 32'h3, 2'h0);
    wr(MD, 32'h10, 2'h0);
    rx(8'h55, 1'b0, 1'b0);
    rx(8'h11, 1'b0, 1'b1);
    rd(ST, 32'h5, 2'h0);
    wr(`CRF_OFF_XON, 32'h21, 2'h0);
    rx(8'h21, 1'b0, 1'b1);
    rx(8'h11, 1'b0, 1'b1);
    rx_fifo_room <= 1'b0;
    rx(8'h13, 1'b0, 1'b0);
    rx_fifo_room <= 1'b1;
    rd(ST, 32'h1, 2'h0);
    wr(MD, 32'h08, 2'h0);
    rx_fill <= 9'h0F0;
    repeat (4) @(posedge aclk);
    chk(tx_fc_req, 1'b0);
    rx_fill <= 9'h0F1;
    repeat (3) @(posedge aclk);
    chk({tx_fc_req, tx_fc_char}, 9'h113);
    repeat (12) @(posedge aclk);
    chk({tx_fc_req, sent_char}, 9'h013);
    rx_fill <= 9'h010;
    repeat (4) @(posedge aclk);
    chk(tx_fc_req, 1'b0);
    rx_fill <= 9'h00F;
    repeat (14) @(posedge aclk);
    chk(sent_char, 8'h21);
    wr(MD, 32'h0C, 2'h0);
    rx_fill <= 9'h0F1;
    rx(8'h13, 1'b0, 1'b1);
    repeat (14) @(posedge aclk);
    chk({tx_enable, sent_char}, 9'h013);
    finish_test;
  end
endmodule
